/* File: rtl/serial_port_fifo_pkg.sv */
package serial_port_fifo_pkg;

    // bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] RX_CFG_OFS = 8'h00;
    localparam logic [7:0] TX_CFG_OFS = 8'h04;
    localparam logic [7:0] RX_STAT_OFS = 8'h08;
    localparam logic [7:0] TX_STAT_OFS = 8'h0C;
    localparam logic [7:0] SETUP_OFS = 8'h10;
    localparam logic [7:0] DATA_OFS = 8'h14;

    // field positions
    localparam int unsigned FLUSH_BIT = 7;
    localparam int unsigned COND_BIT = 6;
    localparam int unsigned OVF_BIT = 7;

    // queue geometry and capacities
    localparam int unsigned DEPTH = 4;
    localparam int unsigned PTR_W = 2;
    localparam int unsigned CNT_W = 3;
    localparam logic [2:0] CAP_HALF = 3'h4;
    localparam logic [2:0] CAP_FULL = 3'h2;
    localparam logic [2:0] CAP_OFF = 3'h1;

    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // threshold config of one queue
    typedef struct packed {
        logic cond_sel;
        logic [1:0] level;
    } queue_cfg_t;

    // queue setup word, bit 3 downward
    typedef struct packed {
        logic idle_keep_running;
        logic channel_run;
        logic half_duplex;
        logic queue_enable;
    } setup_t;

    // one received byte from the shift logic
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_beat_t;

    // values after reset
    localparam queue_cfg_t CFG_RESET = 3'h0;
    localparam setup_t SETUP_RESET = 4'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

/* File: rtl/serial_port_fifo_control.sv */
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// What this block does
// - receive flush empties queue, zeroes count, pointers
// - select set: receive irq when count >= threshold
// - half duplex receive levels 4,1,2,3
// - full duplex receive levels 2,1,2,1
// - transmit flush empties queue, zeroes count, pointers
// - select set: transmit irq when count <= threshold
// - half duplex transmit levels 0,1,2,3
// - full duplex transmit levels 0,1,0,1
// - receive overrun sets overflow flag
// - reading data port clears overflow flag
// - receive count reports zero to four bytes
// - stop or idle stop resets transmit config
// - transmit count reports zero to four bytes
module serial_port_fifo_control (
    input wire logic clk_i, // 20 mhz peripheral clock
    input wire logic reset_i, // async reset, active high
    input wire logic [serial_port_fifo_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [serial_port_fifo_pkg::ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic idle_i, // chip is in idle mode
    input serial_port_fifo_pkg::byte_beat_t rx_beat_i, // byte from receive shifter
    output logic rx_ready_o, // receive side accepts bytes
    output logic [7:0] tx_data_o, // byte to transmit shifter
    output logic tx_valid_o, // transmit byte valid
    input wire logic tx_ready_i, // transmit shifter takes byte
    output logic rx_irq_o, // receive interrupt level
    output logic tx_irq_o // transmit interrupt level
);
    import serial_port_fifo_pkg::*;

    // bus slave state
    logic aw_have_q, aw_have_d; // write address held
    logic w_have_q, w_have_d; // write data held
    logic [ADDR_W-1:0] wr_addr_q, wr_addr_d; // held write address
    logic [31:0] wr_data_q, wr_data_d; // held write data
    logic [3:0] wr_strb_q, wr_strb_d; // held byte enables
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [ADDR_W-1:0] rd_addr_q, rd_addr_d; // last read address, for checks

    // register state
    queue_cfg_t rx_cfg_q, rx_cfg_d; // receive threshold config
    queue_cfg_t tx_cfg_q, tx_cfg_d; // transmit threshold config
    setup_t setup_q, setup_d; // mode and run bits
    logic ovf_q, ovf_d; // receive overflow flag
    logic rx_irq_q, rx_irq_d;
    logic tx_irq_q, tx_irq_d;
    logic rx_ready_q, rx_ready_d;

    // queue state
    logic [7:0] rx_mem_q [DEPTH];
    logic [7:0] rx_mem_d [DEPTH];
    logic [7:0] tx_mem_q [DEPTH];
    logic [7:0] tx_mem_d [DEPTH];
    logic [PTR_W-1:0] rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
    logic [PTR_W-1:0] tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d;
    logic [CNT_W-1:0] rx_cnt_q, rx_cnt_d; // receive fill count
    logic [CNT_W-1:0] tx_cnt_q, tx_cnt_d; // transmit fill count

    // two-entry output buffer toward the shifter
    logic out_v_q, out_v_d;
    logic [7:0] out_q, out_d;
    logic skid_v_q, skid_v_d;
    logic [7:0] skid_q, skid_d;

    // decoded strobes
    logic do_write; // both halves of a write are held
    logic ar_take; // read address taken this cycle
    logic wr_hit_rx_cfg, wr_hit_tx_cfg, wr_hit_setup, wr_hit_data;
    logic rd_data; // read of the data port
    logic rx_flush, tx_flush; // flush strobes
    logic rx_push, rx_pop, rx_overrun;
    logic tx_push, tx_pop;
    logic [2:0] rx_cap, tx_cap; // capacity for the current mode
    logic [2:0] rx_lvl, tx_lvl; // decoded thresholds
    logic tx_cfg_kill; // channel stopped or idle stop

    // capacity shrinks in full duplex; disabled queue acts as one byte holder
    function automatic logic [2:0] cap_of(input setup_t s);
        if (!s.queue_enable) begin
            return CAP_OFF;
        end
        return s.half_duplex ? CAP_HALF : CAP_FULL;
    endfunction

    // write and read decode, only byte lane 0 carries fields
    always_comb begin
        do_write = aw_have_q && w_have_q && !bvalid_q;
        ar_take = s_axi_arvalid && arready_q;
        wr_hit_rx_cfg = do_write && wr_strb_q[0] && (wr_addr_q == RX_CFG_OFS);
        wr_hit_tx_cfg = do_write && wr_strb_q[0] && (wr_addr_q == TX_CFG_OFS);
        wr_hit_setup = do_write && wr_strb_q[0] && (wr_addr_q == SETUP_OFS);
        wr_hit_data = do_write && wr_strb_q[0] && (wr_addr_q == DATA_OFS);
        // same word alignment as the read mux, so a pop always matches the data returned
        rd_data = ar_take && ({s_axi_araddr[ADDR_W-1:2], 2'b00} == DATA_OFS);
        rx_flush = wr_hit_rx_cfg && wr_data_q[FLUSH_BIT];
        tx_flush = wr_hit_tx_cfg && wr_data_q[FLUSH_BIT];
    end

    // threshold decode per duplex mode
    always_comb begin
        if (setup_q.half_duplex) begin
            rx_lvl = (rx_cfg_q.level == 2'h0) ? 3'h4 : {1'b0, rx_cfg_q.level};
            tx_lvl = {1'b0, tx_cfg_q.level};
        end else begin
            rx_lvl = rx_cfg_q.level[0] ? 3'h1 : 3'h2;
            tx_lvl = tx_cfg_q.level[0] ? 3'h1 : 3'h0;
        end
    end

    // axi4-lite slave, one write and one read in flight
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        wr_addr_d = wr_addr_q;
        wr_data_d = wr_data_q;
        wr_strb_d = wr_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        rd_addr_d = rd_addr_q;
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            wr_addr_d = {s_axi_awaddr[ADDR_W-1:2], 2'b00};
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            wr_data_d = s_axi_wdata;
            wr_strb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_write) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            // read-only status words take the write silently
            case (wr_addr_q)
                RX_CFG_OFS, TX_CFG_OFS, RX_STAT_OFS, TX_STAT_OFS,
                SETUP_OFS, DATA_OFS: bresp_d = RESP_OKAY;
                default: bresp_d = RESP_SLVERR;
            endcase
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (ar_take) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rd_addr_d = {s_axi_araddr[ADDR_W-1:2], 2'b00};
            // reserved and strobe bits read as zero
            case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
                RX_CFG_OFS: rdata_d = {24'h00_0000, 1'b0, rx_cfg_q.cond_sel, 4'h0,
                                       rx_cfg_q.level};
                TX_CFG_OFS: rdata_d = {24'h00_0000, 1'b0, tx_cfg_q.cond_sel, 4'h0,
                                       tx_cfg_q.level};
                RX_STAT_OFS: rdata_d = {24'h00_0000, ovf_q, 4'h0, rx_cnt_q};
                TX_STAT_OFS: rdata_d = {24'h00_0000, 5'h00, tx_cnt_q};
                SETUP_OFS: rdata_d = {28'h000_0000, setup_q};
                DATA_OFS: rdata_d = (rx_cnt_q != 3'h0) ? {24'h00_0000, rx_mem_q[rx_rp_q]}
                                                       : WORD_ZERO;
                default: begin
                    rdata_d = WORD_ZERO;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    // software registers, transmit config drops back while stopped
    always_comb begin
        rx_cfg_d = rx_cfg_q;
        tx_cfg_d = tx_cfg_q;
        setup_d = setup_q;
        tx_cfg_kill = !setup_q.channel_run || (idle_i && !setup_q.idle_keep_running);
        if (wr_hit_rx_cfg) begin
            rx_cfg_d = {wr_data_q[COND_BIT], wr_data_q[1:0]};
        end
        if (wr_hit_tx_cfg) begin
            tx_cfg_d = {wr_data_q[COND_BIT], wr_data_q[1:0]};
        end
        if (wr_hit_setup) begin
            setup_d = wr_data_q[3:0];
        end
        if (tx_cfg_kill) begin
            tx_cfg_d = CFG_RESET;
        end
        rx_ready_d = setup_q.channel_run;
    end

    // receive queue: bytes from the shifter, popped by data port reads
    always_comb begin
        rx_cap = cap_of(setup_q);
        rx_push = rx_beat_i.valid && rx_ready_q && (rx_cnt_q < rx_cap);
        rx_overrun = rx_beat_i.valid && rx_ready_q && (rx_cnt_q >= rx_cap);
        rx_pop = rd_data && (rx_cnt_q != 3'h0);
        rx_wp_d = rx_push ? rx_wp_q + 2'h1 : rx_wp_q;
        rx_rp_d = rx_pop ? rx_rp_q + 2'h1 : rx_rp_q;
        rx_cnt_d = rx_cnt_q + {2'b00, rx_push} - {2'b00, rx_pop};
        // flush beats a push or pop in the same cycle
        if (rx_flush) begin
            rx_wp_d = 2'h0;
            rx_rp_d = 2'h0;
            rx_cnt_d = 3'h0;
        end
        // a new overrun wins over the clearing read
        ovf_d = (ovf_q && !rd_data) || rx_overrun;
        rx_irq_d = rx_cfg_q.cond_sel ? (rx_cnt_q >= rx_lvl) : (rx_cnt_q == rx_lvl);
    end

    // transmit queue: filled by data port writes, drained into the buffer
    always_comb begin
        tx_cap = cap_of(setup_q);
        tx_push = wr_hit_data && (tx_cnt_q < tx_cap); // a write to a full queue is dropped
        tx_pop = (tx_cnt_q != 3'h0) && !skid_v_q; // buffer stall holds the queue
        tx_wp_d = tx_push ? tx_wp_q + 2'h1 : tx_wp_q;
        tx_rp_d = tx_pop ? tx_rp_q + 2'h1 : tx_rp_q;
        tx_cnt_d = tx_cnt_q + {2'b00, tx_push} - {2'b00, tx_pop};
        if (tx_flush) begin
            tx_wp_d = 2'h0;
            tx_rp_d = 2'h0;
            tx_cnt_d = 3'h0;
        end
        tx_irq_d = tx_cfg_q.cond_sel ? (tx_cnt_q <= tx_lvl) : (tx_cnt_q == tx_lvl);
    end

    // queue storage, one writer per entry
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        assign rx_mem_d[i] = (rx_push && rx_wp_q == PTR_W'(i)) ? rx_beat_i.data
                                                                : rx_mem_q[i];
        assign tx_mem_d[i] = (tx_push && tx_wp_q == PTR_W'(i)) ? wr_data_q[7:0]
                                                                : tx_mem_q[i];
    end

    // output buffer: second slot catches a byte while the shifter stalls
    always_comb begin
        out_v_d = out_v_q;
        out_d = out_q;
        skid_v_d = skid_v_q;
        skid_d = skid_q;
        if (!out_v_q || tx_ready_i) begin
            if (skid_v_q) begin
                out_v_d = 1'b1;
                out_d = skid_q;
                skid_v_d = 1'b0;
            end else begin
                out_v_d = tx_pop;
                out_d = tx_mem_q[tx_rp_q];
            end
        end else if (tx_pop) begin
            skid_v_d = 1'b1;
            skid_d = tx_mem_q[tx_rp_q];
        end
    end

    // one register stage for everything above
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= WORD_ZERO;
            wr_strb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= WORD_ZERO;
            rd_addr_q <= 8'h00;
            rx_cfg_q <= CFG_RESET;
            tx_cfg_q <= CFG_RESET;
            setup_q <= SETUP_RESET;
            ovf_q <= 1'b0;
            rx_irq_q <= 1'b0;
            tx_irq_q <= 1'b0;
            rx_ready_q <= 1'b0;
            rx_wp_q <= 2'h0;
            rx_rp_q <= 2'h0;
            tx_wp_q <= 2'h0;
            tx_rp_q <= 2'h0;
            rx_cnt_q <= 3'h0;
            tx_cnt_q <= 3'h0;
            out_v_q <= 1'b0;
            out_q <= 8'h00;
            skid_v_q <= 1'b0;
            skid_q <= 8'h00;
            for (int k = 0; k < DEPTH; k++) begin
                rx_mem_q[k] <= 8'h00;
                tx_mem_q[k] <= 8'h00;
            end
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            wr_addr_q <= wr_addr_d;
            wr_data_q <= wr_data_d;
            wr_strb_q <= wr_strb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            rd_addr_q <= rd_addr_d;
            rx_cfg_q <= rx_cfg_d;
            tx_cfg_q <= tx_cfg_d;
            setup_q <= setup_d;
            ovf_q <= ovf_d;
            rx_irq_q <= rx_irq_d;
            tx_irq_q <= tx_irq_d;
            rx_ready_q <= rx_ready_d;
            rx_wp_q <= rx_wp_d;
            rx_rp_q <= rx_rp_d;
            tx_wp_q <= tx_wp_d;
            tx_rp_q <= tx_rp_d;
            rx_cnt_q <= rx_cnt_d;
            tx_cnt_q <= tx_cnt_d;
            out_v_q <= out_v_d;
            out_q <= out_d;
            skid_v_q <= skid_v_d;
            skid_q <= skid_d;
            rx_mem_q <= rx_mem_d;
            tx_mem_q <= tx_mem_d;
        end
    end

    // ports straight from flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign rx_ready_o = rx_ready_q;
    assign tx_valid_o = out_v_q;
    assign tx_data_o = out_q;
    assign rx_irq_o = rx_irq_q;
    assign tx_irq_o = tx_irq_q;

    // checks, all on the one clock
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    property p_rx_flush;
        rx_flush |=> (rx_cnt_q == 3'h0) && (rx_rp_q == 2'h0);
    endproperty
    a_rx_flush: assert property (p_rx_flush) else $error("rx flush left data");

    property p_rx_irq_ge;
        (rx_cfg_q.cond_sel && rx_cnt_q >= rx_lvl) |=> rx_irq_o;
    endproperty
    a_rx_irq_ge: assert property (p_rx_irq_ge) else $error("rx irq missing");

    property p_rx_half_lvl;
        (setup_q.half_duplex && rx_cfg_q.level == 2'h0) |-> rx_lvl == 3'h4;
    endproperty
    a_rx_half_lvl: assert property (p_rx_half_lvl) else $error("rx half level");

    property p_rx_full_lvl;
        !setup_q.half_duplex |-> rx_lvl == (rx_cfg_q.level[0] ? 3'h1 : 3'h2);
    endproperty
    a_rx_full_lvl: assert property (p_rx_full_lvl) else $error("rx full level");

    property p_tx_flush;
        tx_flush |=> (tx_cnt_q == 3'h0) && (tx_wp_q == 2'h0);
    endproperty
    a_tx_flush: assert property (p_tx_flush) else $error("tx flush left data");

    property p_tx_irq_le;
        (tx_cfg_q.cond_sel && tx_cnt_q <= tx_lvl) |=> tx_irq_o;
    endproperty
    a_tx_irq_le: assert property (p_tx_irq_le) else $error("tx irq missing");

    property p_tx_half_lvl;
        setup_q.half_duplex |-> tx_lvl == {1'b0, tx_cfg_q.level};
    endproperty
    a_tx_half_lvl: assert property (p_tx_half_lvl) else $error("tx half level");

    property p_tx_full_lvl;
        (!setup_q.half_duplex && tx_cfg_q.level == 2'h2) |-> tx_lvl == 3'h0;
    endproperty
    a_tx_full_lvl: assert property (p_tx_full_lvl) else $error("tx full level");

    property p_ovf_set;
        (rx_beat_i.valid && rx_ready_o && rx_cnt_q == rx_cap) |=> ovf_q;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overrun not flagged");

    property p_ovf_clr;
        (rd_data && !rx_overrun) |=> !ovf_q;
    endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow not cleared");

    property p_counts;
        (rx_cnt_q <= CAP_HALF) && (tx_cnt_q <= CAP_HALF);
    endproperty
    a_counts: assert property (p_counts) else $error("fill count beyond four");

    property p_tx_cfg_stop;
        (!setup_q.channel_run || (idle_i && !setup_q.idle_keep_running))
            |=> tx_cfg_q == CFG_RESET;
    endproperty
    a_tx_cfg_stop: assert property (p_tx_cfg_stop) else $error("tx config kept");

    property p_flush_reads_zero;
        (rvalid_q && (rd_addr_q == RX_CFG_OFS || rd_addr_q == TX_CFG_OFS))
            |-> s_axi_rdata[31:7] == 25'h000_0000;
    endproperty
    a_flush_reads_zero: assert property (p_flush_reads_zero) else $error("bad cfg read");

    c_rx_full: cover property (rx_cnt_q == CAP_HALF);
    c_overrun: cover property (rx_overrun);
    c_tx_stall: cover property (skid_v_q && out_v_q && !tx_ready_i);
    c_flush_both: cover property (rx_flush ##[1:20] tx_flush);

endmodule

/* File: sim/serial_shifter_model.sv */
`timescale 1ns/1ps
// far-side shifter: feeds received bytes, takes transmit bytes
module serial_shifter_model (
    input wire logic clk_i, // peripheral clock
    input wire logic rx_ready_i, // block accepts bytes
    output serial_port_fifo_pkg::byte_beat_t rx_beat_o, // byte towards block
    input wire logic stall_i, // hold transmit side off
    input wire logic slow_i, // take every other cycle
    output logic tx_ready_o // shifter takes byte
);
    import serial_port_fifo_pkg::*;
    initial begin
        rx_beat_o = '0;
        tx_ready_o = 1'b0;
    end
    // slow mode leaves gaps so the block must hold its byte
    always @(posedge clk_i) begin
        tx_ready_o <= !stall_i && (!slow_i || !tx_ready_o);
    end
    // hold a byte until taken; the idle line then shows junk, not the old byte
    task automatic send(input logic [7:0] d);
        rx_beat_o <= '{valid: 1'b1, data: d};
        do @(posedge clk_i); while (!rx_ready_i);
        rx_beat_o <= '{valid: 1'b0, data: ~d};
        @(posedge clk_i);
    endtask
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
// register traffic, receive levels and overrun, transmit drain and stop
module tb_top;
    import serial_port_fifo_pkg::*;
    logic clk_i, reset_i, idle_i, stall, slow; // clock, reset, idle, partner knobs
    logic [7:0] awaddr, araddr, lf, tx_data; // addresses, random state, tx byte
    logic [31:0] wdata, rdata; // bus words
    logic awvalid, wvalid, bready, arvalid, rready; // master handshakes
    logic awready, wready, bvalid, arready, rvalid, rx_ready, tx_valid, tx_ready, rx_irq, tx_irq;
    logic [1:0] bresp, rresp; // responses
    byte_beat_t rx_beat; // receive byte
    logic [33:0] exp_r[$]; // expected read response and word
    logic [1:0] exp_b[$]; // expected write response
    logic [7:0] exp_t[$], sent[$]; // expected tx bytes, bytes sent in
    int n_mismatch = 0, samples_checked = 0;
    int lv[2][4] = '{'{4, 1, 2, 3}, '{2, 1, 2, 1}}; // receive levels, half then full
    int tl[2][4] = '{'{0, 1, 2, 3}, '{0, 1, 0, 1}}; // transmit levels, half then full
    serial_port_fifo_control u_dut (.clk_i(clk_i), .reset_i(reset_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .idle_i(idle_i), .rx_beat_i(rx_beat), .rx_ready_o(rx_ready), .tx_data_o(tx_data),
        .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .rx_irq_o(rx_irq), .tx_irq_o(tx_irq));
    serial_shifter_model u_part (.clk_i(clk_i), .rx_ready_i(rx_ready), .rx_beat_o(rx_beat),
        .stall_i(stall), .slow_i(slow), .tx_ready_o(tx_ready));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // results are judged here, in the order they were noted
    always @(posedge clk_i) begin
        if (bvalid && bready) chk(bresp, exp_b.pop_front(), "bresp");
        if (rvalid && rready) chk({rresp, rdata}, exp_r.pop_front(), "read");
        if (tx_valid && tx_ready) chk(tx_data, exp_t.pop_front(), "tx byte");
    end
    // each channel released once taken; trailing edge keeps drivers apart
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        exp_b.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        exp_r.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic push();
        lf = nxt(lf);
        sent.push_back(lf);
        u_part.send(lf);
    endtask
    // mode setup, then both flushes as software must
    task automatic mode(input logic [3:0] s);
        wr(SETUP_OFS, {28'h000_0000, s});
        wr(RX_CFG_OFS, 32'h0000_0080);
        wr(TX_CFG_OFS, 32'h0000_0080);
        sent.delete();
    endtask
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        summarize();
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, stall, slow, idle_i} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        lf = 8'h49;
        reset_i = 1'b1;
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd(RX_CFG_OFS, WORD_ZERO);
        rd(RX_STAT_OFS, WORD_ZERO);
        rd(8'h1C, WORD_ZERO, RESP_SLVERR);
        wr(8'h18, 32'hFFFF_FFFF, RESP_SLVERR);
        $display("test reset done");
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 4; c++) begin
                mode(m ? 4'h5 : 4'h7);
                wr(RX_CFG_OFS, 32'h0000_0040 + 32'(c));
                wr(TX_CFG_OFS, 32'(c));
                repeat (lv[m][c] - 1) push();
                repeat (3) @(posedge clk_i);
                chk(rx_irq, 1'b0, "rx irq below");
                chk(tx_irq, tl[m][c] == 0, "tx level");
                push();
                repeat (3) @(posedge clk_i);
                chk(rx_irq, 1'b1, "rx irq at level");
                rd(RX_STAT_OFS, 32'(lv[m][c]));
            end
        end
        $display("test levels done");
        mode(4'h7);
        repeat (5) push();
        repeat (2) @(posedge clk_i);
        rd(RX_STAT_OFS, 32'h0000_0084);
        rd(DATA_OFS, {24'h00_0000, sent[0]});
        rd(RX_STAT_OFS, 32'h0000_0003);
        wr(RX_CFG_OFS, 32'hFFFF_FFC3);
        rd(RX_STAT_OFS, WORD_ZERO);
        rd(RX_CFG_OFS, 32'h0000_0043);
        $display("test overrun done");
        stall <= 1'b1;
        wr(TX_CFG_OFS, 32'h0000_0041);
        repeat (4) begin
            lf = nxt(lf);
            exp_t.push_back(lf);
            wr(DATA_OFS, {24'h00_0000, lf});
        end
        chk(tx_irq, 1'b0, "tx irq above");
        slow <= 1'b1;
        stall <= 1'b0;
        repeat (30) @(posedge clk_i);
        rd(TX_STAT_OFS, WORD_ZERO);
        chk(tx_irq, 1'b1, "tx irq drained");
        wr(SETUP_OFS, 32'h0000_0003);
        rd(TX_CFG_OFS, WORD_ZERO);
        wr(SETUP_OFS, 32'h0000_0007);
        wr(TX_CFG_OFS, 32'h0000_0041);
        idle_i <= 1'b1;
        @(posedge clk_i);
        rd(TX_CFG_OFS, WORD_ZERO);
        $display("test transmit done");
        summarize();
    end
endmodule
